// ==== scwc_top.sv ====
// serial channel write configuration bank with an APB slave
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
module scwc_top
  import scwc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // modem handshake pins
  input wire logic cts_n_pin,
  input wire logic dcd_n_pin,
  // receiver controls
  output logic [3:0] rx_char_bits,
  output logic rx_auto_enable,
  output logic rx_hunt_pulse,
  output logic rx_crc_enable,
  output logic rx_addr_search,
  output logic rx_sync_load_inhibit,
  output logic rx_enable,
  output logic rx_assemble_enable,
  // transmitter controls
  output logic [3:0] tx_char_bits,
  output logic tx_enable,
  output logic tx_gate_enable,
  output logic tx_send_break,
  output logic tx_crc_enable,
  output logic tx_crc_select,
  output logic dtr_out,
  output logic rts_out,
  // other configuration bytes
  output logic [7:0] int_dma_control,
  output logic [7:0] interrupt_vector_value,
  output logic [7:0] clock_stop_sync_mode,
  output logic [7:0] sync_or_station_address
);
  import scwc_pkg::*;

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_sync1_reg;
  logic rst_sync1_next;
  logic rst_sync2_reg;
  logic rst_sync2_next;
  logic rst_n;

  // release waits two edges so no flop sees reset end close to an edge
  always_comb begin
    rst_sync1_next = 1'b1;
    rst_sync2_next = rst_sync1_reg;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end else begin
      rst_sync1_reg <= rst_sync1_next;
      rst_sync2_reg <= rst_sync2_next;
    end
  end
  assign rst_n = rst_sync2_reg;

  // ----------------------------------------
  // modem pin synchronisers
  // ----------------------------------------
  logic [1:0] pin_s1_reg;
  logic [1:0] pin_s1_next;
  logic [1:0] pin_s2_reg;
  logic [1:0] pin_s2_next;

  // only the second stage is read by logic
  always_comb begin
    pin_s1_next = {dcd_n_pin, cts_n_pin};
    pin_s2_next = pin_s1_reg;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_reg <= 2'h3;
      pin_s2_reg <= 2'h3;
    end else begin
      pin_s1_reg <= pin_s1_next;
      pin_s2_reg <= pin_s2_next;
    end
  end

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  logic access;
  logic wr_access;
  logic rd_access;
  logic addr_mapped;
  logic [SCWC_NUM_WO-1:0] wr_sel;
  logic sw_hw_reset;
  logic hw_reset_pulse;

  assign access = psel && penable;
  assign wr_access = access && pwrite && pstrb[0];
  assign rd_access = access && !pwrite;

  always_comb begin
    wr_sel = '0;
    addr_mapped = 1'b1;
    sw_hw_reset = 1'b0;
    unique case (paddr)
      SCWC_OFF_INT_DMA: wr_sel[0] = wr_access;
      SCWC_OFF_VECTOR: wr_sel[1] = wr_access;
      SCWC_OFF_RX_PARAM: wr_sel[2] = wr_access;
      SCWC_OFF_CLK_MODE: wr_sel[3] = wr_access;
      SCWC_OFF_TX_PARAM: wr_sel[4] = wr_access;
      SCWC_OFF_SYNC_ADDR: wr_sel[5] = wr_access;
      SCWC_OFF_STATUS: addr_mapped = 1'b1;
      SCWC_OFF_HW_RESET: sw_hw_reset = wr_access && pwdata[0];
      default: addr_mapped = 1'b0;
    endcase
  end

  // software reset re-applies documented reset values one cycle later
  logic hw_rst_reg;
  logic hw_rst_next;
  always_comb begin
    hw_rst_next = sw_hw_reset;
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hw_rst_reg <= 1'b0;
    end else begin
      hw_rst_reg <= hw_rst_next;
    end
  end
  assign hw_reset_pulse = hw_rst_reg;

  // ----------------------------------------
  // configuration bytes
  // ----------------------------------------
  logic [7:0] rx_param;
  logic [7:0] tx_param;
  logic [7:0] rx_param_wdata;

  // hunt bit is a command, not stored state
  assign rx_param_wdata = pwdata[7:0] & ~(8'h01 << SCWC_RX_HUNT);

  scwc_cfg_reg #(.RESET_VALUE(SCWC_RST_INT_DMA), .RESET_MASK(SCWC_MSK_INT_DMA)) u_int_dma (
    .clk(sys_clk),
    .rst_n(rst_n),
    .hw_reset(hw_reset_pulse),
    .wr_en(wr_sel[0]),
    .wr_data(pwdata[7:0]),
    .value(int_dma_control)
  );

  scwc_cfg_reg #(.RESET_VALUE(SCWC_RST_OTHER), .RESET_MASK(SCWC_RST_OTHER)) u_vector (
    .clk(sys_clk),
    .rst_n(rst_n),
    .hw_reset(hw_reset_pulse),
    .wr_en(wr_sel[1]),
    .wr_data(pwdata[7:0]),
    .value(interrupt_vector_value)
  );

  scwc_cfg_reg #(.RESET_VALUE(SCWC_RST_RX_PARAM), .RESET_MASK(SCWC_MSK_RX_PARAM)) u_rx_param (
    .clk(sys_clk),
    .rst_n(rst_n),
    .hw_reset(hw_reset_pulse),
    .wr_en(wr_sel[2]),
    .wr_data(rx_param_wdata),
    .value(rx_param)
  );

  scwc_cfg_reg #(.RESET_VALUE(SCWC_RST_CLK_MODE), .RESET_MASK(SCWC_MSK_CLK_MODE)) u_clk_mode (
    .clk(sys_clk),
    .rst_n(rst_n),
    .hw_reset(hw_reset_pulse),
    .wr_en(wr_sel[3]),
    .wr_data(pwdata[7:0]),
    .value(clock_stop_sync_mode)
  );

  scwc_cfg_reg #(.RESET_VALUE(SCWC_RST_TX_PARAM), .RESET_MASK(SCWC_MSK_TX_PARAM)) u_tx_param (
    .clk(sys_clk),
    .rst_n(rst_n),
    .hw_reset(hw_reset_pulse),
    .wr_en(wr_sel[4]),
    .wr_data(pwdata[7:0]),
    .value(tx_param)
  );

  scwc_cfg_reg #(.RESET_VALUE(SCWC_RST_OTHER), .RESET_MASK(SCWC_RST_OTHER)) u_sync_addr (
    .clk(sys_clk),
    .rst_n(rst_n),
    .hw_reset(hw_reset_pulse),
    .wr_en(wr_sel[5]),
    .wr_data(pwdata[7:0]),
    .value(sync_or_station_address)
  );

  // ----------------------------------------
  // hunt command and status
  // ----------------------------------------
  logic hunt_reg;
  logic hunt_next;
  logic hunt_seen_reg;
  logic hunt_seen_next;
  logic status_rd;

  assign status_rd = rd_access && (paddr == SCWC_OFF_STATUS);

  always_comb begin
    hunt_next = wr_sel[2] && pwdata[SCWC_RX_HUNT];
    hunt_seen_next = hunt_seen_reg;
    // a new hunt request wins over the read-clear
    if (hunt_reg) begin
      hunt_seen_next = 1'b1;
    end else if (status_rd) begin
      hunt_seen_next = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hunt_reg <= 1'b0;
      hunt_seen_reg <= 1'b0;
    end else begin
      hunt_reg <= hunt_next;
      hunt_seen_reg <= hunt_seen_next;
    end
  end

  // ----------------------------------------
  // decoded controls
  // ----------------------------------------
  function automatic logic [3:0] scwc_len_bits(input logic [1:0] code);
    logic [3:0] bits;
    bits = SCWC_BITS_8;
    unique case (scwc_char_len_t'(code))
      SCWC_LEN_5: bits = SCWC_BITS_5;
      SCWC_LEN_7: bits = SCWC_BITS_7;
      SCWC_LEN_6: bits = SCWC_BITS_6;
      SCWC_LEN_8: bits = SCWC_BITS_8;
    endcase
    return bits;
  endfunction

  logic gate_rx;
  logic gate_tx;

  assign rx_char_bits = scwc_len_bits(rx_param[SCWC_RX_LEN_HI:SCWC_RX_LEN_LO]);
  assign tx_char_bits = scwc_len_bits(tx_param[SCWC_TX_LEN_HI:SCWC_TX_LEN_LO]);
  assign rx_auto_enable = rx_param[SCWC_RX_AUTO_EN];
  assign rx_hunt_pulse = hunt_reg;
  assign rx_crc_enable = rx_param[SCWC_RX_CRC_EN];
  assign rx_addr_search = rx_param[SCWC_RX_ADDR_SRCH];
  assign rx_sync_load_inhibit = rx_param[SCWC_RX_SYNC_INH];
  assign rx_enable = rx_param[SCWC_RX_ENABLE];

  // with auto enable, carrier gates the receiver and clear-to-send the transmitter
  assign gate_rx = !rx_auto_enable || !pin_s2_reg[1];
  assign gate_tx = !rx_auto_enable || !pin_s2_reg[0];
  assign rx_assemble_enable = rx_enable && gate_rx;
  assign tx_enable = tx_param[SCWC_TX_ENABLE];
  assign tx_gate_enable = tx_enable && gate_tx;
  assign tx_send_break = tx_param[SCWC_TX_BREAK];
  assign tx_crc_enable = tx_param[SCWC_TX_CRC_EN];
  assign tx_crc_select = tx_param[SCWC_TX_CRC_SEL];
  assign dtr_out = tx_param[SCWC_TX_DTR];
  assign rts_out = tx_param[SCWC_TX_RTS];

  // ----------------------------------------
  // read path
  // ----------------------------------------
  logic [31:0] rdata;
  always_comb begin
    // config bytes are write-only: they read as fill
    rdata = SCWC_READ_FILL;
    if (paddr == SCWC_OFF_STATUS) begin
      rdata = {26'h0, pin_s2_reg, hunt_seen_reg, hw_rst_reg, rx_assemble_enable, tx_gate_enable};
    end
  end

  assign prdata = rdata;
  // zero wait states: unmapped addresses flag an error but never stall the bus
  assign pready = 1'b1;
  assign pslverr = access && !addr_mapped;
endmodule // scwc_top

// ==== scwc_pkg.sv ====
// package: offsets, field layouts and reset values of the write configuration bank
package scwc_pkg;
  // ----------------------------------------
  // register byte offsets (one word each)
  // ----------------------------------------
  localparam logic [11:0] SCWC_OFF_INT_DMA = 12'h004;
  localparam logic [11:0] SCWC_OFF_VECTOR = 12'h008;
  localparam logic [11:0] SCWC_OFF_RX_PARAM = 12'h00C;
  localparam logic [11:0] SCWC_OFF_CLK_MODE = 12'h010;
  localparam logic [11:0] SCWC_OFF_TX_PARAM = 12'h014;
  localparam logic [11:0] SCWC_OFF_SYNC_ADDR = 12'h018;
  localparam logic [11:0] SCWC_OFF_STATUS = 12'h040;
  localparam logic [11:0] SCWC_OFF_HW_RESET = 12'h044;
  localparam int SCWC_REG_W = 8;
  localparam int SCWC_NUM_WO = 6;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int SCWC_RX_LEN_HI = 7;
  localparam int SCWC_RX_LEN_LO = 6;
  localparam int SCWC_RX_AUTO_EN = 5;
  localparam int SCWC_RX_HUNT = 4;
  localparam int SCWC_RX_CRC_EN = 3;
  localparam int SCWC_RX_ADDR_SRCH = 2;
  localparam int SCWC_RX_SYNC_INH = 1;
  localparam int SCWC_RX_ENABLE = 0;
  localparam int SCWC_TX_DTR = 7;
  localparam int SCWC_TX_LEN_HI = 6;
  localparam int SCWC_TX_LEN_LO = 5;
  localparam int SCWC_TX_BREAK = 4;
  localparam int SCWC_TX_ENABLE = 3;
  localparam int SCWC_TX_CRC_SEL = 2;
  localparam int SCWC_TX_RTS = 1;
  localparam int SCWC_TX_CRC_EN = 0;

  // ----------------------------------------
  // character length codes and bit counts
  // ----------------------------------------
  typedef enum logic [1:0] {
    SCWC_LEN_5 = 2'h0,
    SCWC_LEN_7 = 2'h1,
    SCWC_LEN_6 = 2'h2,
    SCWC_LEN_8 = 2'h3
  } scwc_char_len_t;
  localparam logic [3:0] SCWC_BITS_5 = 4'h5;
  localparam logic [3:0] SCWC_BITS_6 = 4'h6;
  localparam logic [3:0] SCWC_BITS_7 = 4'h7;
  localparam logic [3:0] SCWC_BITS_8 = 4'h8;

  // ----------------------------------------
  // hardware reset values and masks (mask bit set = field has a reset value)
  // ----------------------------------------
  localparam logic [7:0] SCWC_RST_INT_DMA = 8'h00;
  localparam logic [7:0] SCWC_MSK_INT_DMA = 8'hDB;
  localparam logic [7:0] SCWC_RST_RX_PARAM = 8'h00;
  localparam logic [7:0] SCWC_MSK_RX_PARAM = 8'h01;
  localparam logic [7:0] SCWC_RST_CLK_MODE = 8'h04;
  localparam logic [7:0] SCWC_MSK_CLK_MODE = 8'h05;
  localparam logic [7:0] SCWC_RST_TX_PARAM = 8'h00;
  localparam logic [7:0] SCWC_MSK_TX_PARAM = 8'h9E;
  localparam logic [7:0] SCWC_RST_OTHER = 8'h00;
  localparam logic [31:0] SCWC_READ_FILL = 32'h0000_0000;
endpackage : scwc_pkg

// ==== scwc_cfg_reg.sv ====
// one write-only configuration byte with partial hardware reset
`timescale 1ns/10ps
module scwc_cfg_reg #(
  parameter logic [7:0] RESET_VALUE = 8'h00,
  parameter logic [7:0] RESET_MASK = 8'h00
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // write port
  input wire logic hw_reset,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  // stored value
  output logic [7:0] value
);
  logic [7:0] value_reg;
  logic [7:0] value_next;

  always_comb begin
    value_next = value_reg;
    if (wr_en) begin
      value_next = wr_data;
    end else if (hw_reset) begin
      // indeterminate fields keep their value
      value_next = (value_reg & ~RESET_MASK) | (RESET_VALUE & RESET_MASK);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      value_reg <= RESET_VALUE;
    end else begin
      value_reg <= value_next;
    end
  end

  assign value = value_reg;
endmodule // scwc_cfg_reg

// ==== scwc_top_assertions.sv ====
// checker: port-level properties of the write configuration bank
`timescale 1ns/10ps
module scwc_chk (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // controls
  input wire logic [3:0] rx_char_bits,
  input wire logic [3:0] tx_char_bits,
  input wire logic rx_hunt_pulse,
  input wire logic rx_auto_enable,
  input wire logic rx_crc_enable,
  input wire logic rx_addr_search,
  input wire logic rx_sync_load_inhibit,
  input wire logic rx_enable
);
  import scwc_pkg::*;
  logic acc, wr, wrx, wtx, hw;
  function automatic logic [3:0] nb(input logic [1:0] c);
    return (c == 2'h0) ? 4'h5 : (c == 2'h1) ? 4'h7 : (c == 2'h2) ? 4'h6 : 4'h8;
  endfunction
  assign acc = psel && penable;
  assign wr = acc && pwrite && pstrb[0];
  assign wrx = wr && (paddr == SCWC_OFF_RX_PARAM);
  assign wtx = wr && (paddr == SCWC_OFF_TX_PARAM);
  assign hw = wrx && pwdata[4];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  a_rx_len_map: assert property (wrx |=> rx_char_bits == nb($past(pwdata[7:6])))
    else $error("rx length mismatch");
  a_rx_len_hold: assert property (!wrx |=> $stable(rx_char_bits))
    else $error("rx length changed without write");
  a_rx_flag_map: assert property (wrx |=> {rx_auto_enable, rx_crc_enable, rx_addr_search,
    rx_sync_load_inhibit, rx_enable} == {$past(pwdata[5]), $past(pwdata[3:0])})
    else $error("rx flag mismatch");
  a_hunt_pulse: assert property (hw |-> ##[1:2] rx_hunt_pulse)
    else $error("hunt pulse missing");
  a_hunt_cause: assert property ($rose(rx_hunt_pulse) |-> $past(hw) || $past(hw, 2))
    else $error("hunt pulse without write");
  a_tx_len_map: assert property (wtx |=> tx_char_bits == nb($past(pwdata[6:5])))
    else $error("tx length mismatch");
  a_wo_read: assert property (acc && !pwrite && paddr >= SCWC_OFF_INT_DMA &&
    paddr <= SCWC_OFF_SYNC_ADDR && paddr[1:0] == 2'h0 |-> prdata == 32'h0 && !pslverr)
    else $error("write-only read returned data");
  a_unmapped_err: assert property (acc && paddr > SCWC_OFF_HW_RESET |-> pslverr)
    else $error("unmapped access not flagged");
endmodule // scwc_chk

bind scwc_top scwc_chk scwc_chk_i (.*);

// ==== scwc_tb_top.sv ====
// testbench: directed scenarios for the write configuration bank
`timescale 1ns/10ps
module scwc_tb_top;
  import scwc_pkg::*;
  // ----
  // signals
  // ----
  logic sys_clk, reset_n, psel, penable, pwrite, cts_n_pin, dcd_n_pin, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, rx_char_bits, tx_char_bits;
  logic pready, pslverr, rx_auto_enable, rx_hunt_pulse, rx_crc_enable, rx_addr_search;
  logic rx_sync_load_inhibit, rx_enable, rx_assemble_enable, tx_enable, tx_gate_enable;
  logic tx_send_break, tx_crc_enable, tx_crc_select, dtr_out, rts_out;
  logic [7:0] int_dma_control, interrupt_vector_value, clock_stop_sync_mode, sync_or_station_address;
  int n_fail = 0;
  int n_tests = 0;
  logic [3:0] lens [4] = '{4'h5, 4'h7, 4'h6, 4'h8};

  scwc_top scwc_top_i (.*);

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // ----
  // shared tasks
  // ----
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // holds the request until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // counts hunt pulses in the three cycles after a write
  task automatic pulses(output int n);
    n = 0;
    repeat (3) begin
      #1;
      n += int'(rx_hunt_pulse === 1'b1);
      @(posedge sys_clk);
    end
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_reset;
    chk("rx_bits", 4'h5, rx_char_bits);
    chk("tx_bits", 4'h5, tx_char_bits);
    chk("rx_en", 1'b0, rx_enable);
    chk("clk_mode", 8'h04, clock_stop_sync_mode);
  endtask
  task automatic t_len;
    int n;
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, SCWC_OFF_RX_PARAM, 32'(c) << 6);
      apb(1'b1, SCWC_OFF_TX_PARAM, 32'(c) << 5);
      #1;
      chk("rx_bits", lens[c], rx_char_bits);
      chk("tx_bits", lens[c], tx_char_bits);
      pulses(n);
      chk("no_hunt", 0, n);
    end
  endtask
  task automatic t_rx_flags;
    int bl [5] = '{5, 3, 2, 1, 0};
    logic [4:0] e;
    foreach (bl[i]) begin
      apb(1'b1, SCWC_OFF_RX_PARAM, 32'h1 << bl[i]);
      #1;
      e = (bl[i] == 5) ? 5'h10 : 5'(1 << bl[i]);
      chk("rx_flags", e, {rx_auto_enable, rx_crc_enable, rx_addr_search, rx_sync_load_inhibit, rx_enable});
    end
  endtask
  task automatic t_auto;
    apb(1'b1, SCWC_OFF_RX_PARAM, 32'h21);
    apb(1'b1, SCWC_OFF_TX_PARAM, 32'h08);
    repeat (4) @(posedge sys_clk);
    chk("rx_gate_off", 1'b0, rx_assemble_enable);
    chk("tx_gate_off", 1'b0, tx_gate_enable);
    cts_n_pin <= 1'b0;
    dcd_n_pin <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk("rx_gate_on", 1'b1, rx_assemble_enable);
    chk("tx_gate_on", 1'b1, tx_gate_enable);
  endtask
  task automatic t_hunt;
    int n;
    apb(1'b1, SCWC_OFF_RX_PARAM, 32'h11);
    pulses(n);
    chk("hunt_once", 1, n);
    chk("rx_en", 1'b1, rx_enable);
    apb(1'b0, SCWC_OFF_STATUS, 32'h0);
    chk("hunt_seen", 1'b1, rd[3]);
    apb(1'b0, SCWC_OFF_STATUS, 32'h0);
    chk("hunt_cleared", 1'b0, rd[3]);
  endtask
  task automatic t_bytes;
    apb(1'b1, SCWC_OFF_INT_DMA, 32'hFF);
    apb(1'b1, SCWC_OFF_CLK_MODE, 32'hFB);
    apb(1'b1, SCWC_OFF_SYNC_ADDR, 32'h81);
    apb(1'b1, SCWC_OFF_TX_PARAM, 32'h97);
    #1;
    chk("vector", 8'hA5, interrupt_vector_value);
    chk("int_dma", 8'hFF, int_dma_control);
    chk("clk_mode", 8'hFB, clock_stop_sync_mode);
    chk("sync_addr", 8'h81, sync_or_station_address);
    chk("tx_ctl", 6'h37, {dtr_out, tx_send_break, tx_enable, tx_crc_select, rts_out, tx_crc_enable});
    apb(1'b1, SCWC_OFF_HW_RESET, 32'h1);
    @(posedge sys_clk);
    #1;
    chk("int_dma_rst", (8'hFF & ~SCWC_MSK_INT_DMA) | SCWC_RST_INT_DMA, int_dma_control);
    chk("clk_mode_rst", (8'hFB & ~SCWC_MSK_CLK_MODE) | SCWC_RST_CLK_MODE, clock_stop_sync_mode);
    chk("tx_ctl_rst", 6'h01, {dtr_out, tx_send_break, tx_enable, tx_crc_select, rts_out, tx_crc_enable});
    chk("vector_kept", 8'hA5, interrupt_vector_value);
    chk("rx_en_rst", 1'b0, rx_enable);
  endtask
  task automatic t_wo;
    apb(1'b1, SCWC_OFF_VECTOR, 32'hA5);
    for (int a = 4; a <= 24; a += 4) begin
      apb(1'b0, 12'(a), 32'h0);
      chk("wo_read", 32'h0, rd);
      chk("wo_err", 1'b0, err);
    end
    apb(1'b1, 12'h100, 32'h0);
    chk("unmapped", 1'b1, err);
    chk("rx_kept", 1'b1, rx_enable);
  endtask
  task automatic close_out;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ----
  // main sequence and watchdog
  // ----
  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    cts_n_pin = 1'b1;
    dcd_n_pin = 1'b1;
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_reset;
    t_len;
    t_rx_flags;
    t_auto;
    t_hunt;
    t_wo;
    t_bytes;
    close_out;
  end
  initial begin
    repeat (2000) @(posedge sys_clk);
    n_fail++;
    close_out;
  end
endmodule // scwc_tb_top
